// *** design/cdreg_bank.sv ***
// Control and status registers for cable reflectometry, link diagnostics and MMD reset.
// Notes on behaviour
// - Bypass bit skips pairs C and D.
// - Cross disable listens only on transmit channel.
// - Link pulse check, reset set, during silence.
// - Averaging code selects 1 to 64 cycles.
// - Reserved averaging code write ignored, field keeps old value.
// - Segment count field, reset value 101.
// - Cycle time field in microseconds, reset 010.
// - Done flag bit 5, result bits 15:8.
// - Clear bit wipes stored diagnostics results.
// - MMD reset returns MMD3 and MMD7 defaults.
// - MMD reset then triggers basic control soft reset.
// - Reserved MMD control bits ignore writes, read zero.
`include "cdreg_defs.svh"
`timescale 1ns/10ps
`default_nettype none
// Overview of the bank.
// The bank holds three registers that software reaches over the management access
// port. Each access lasts exactly one cycle. The port carries a write strobe, a read
// strobe, a flag that selects the indirect MMD3 space, a 16-bit address and write data.
// The bank takes a request on the rising edge at which a strobe is high. It never
// inserts a wait state, so requests may follow each other on consecutive edges.
//
// Reflectometry configuration register.
// Bit 12 makes the measurement engine skip pairs C and D.
// Bit 11 stops the engine listening on cross pairs, so it hears only its own transmitter.
// Bit 10 enables the check for link pulses in the silent period; it comes up set.
// Bits 9:7 select the number of averaged cycles, from 1 up to 64 in powers of two.
// Bits 6:4 hold the number of segments that the engine checks.
// Bits 3:0 hold the length of each cycle in microseconds.
// Bits 15:13 are reserved: writes are dropped and they read as zero.
// The averaging code 111 is reserved. A write carrying it leaves the stored code as it
// was, so the engine never sees an undefined averaging count. The other fields of the
// same write still land, because software often writes the whole word at once.
//
// Diagnostics control register.
// Bits 15:8 hold the last result that the engine reported, and bit 5 the completion flag.
// Both are latched from the engine's report port whenever its done strobe is high.
// Bit 4 is a self clearing clear command. Writing it wipes the stored result and drops
// the completion flag, and raises a one-cycle clear pulse towards the engine.
// A finish that lands in the very cycle of the clear is kept. Losing it would leave
// software waiting for a completion that had in fact already happened.
// Bits 7:6 and 3:0 are reserved and read as zero.
//
// Mmd_set_reset control register in the MMD3 space.
// Only the indirect path reaches it; a direct access at the same offset is a different
// register and must never fire the reset.
// Bit 15 is a self clearing reset of the MMD3 and MMD7 sets. Writing it raises a
// one-cycle pulse on the MMD reset output. One cycle later a one-cycle soft reset pulse
// follows, which the basic control register treats like its own reset bit.
// Bits 14:0 are reserved. The whole register always reads zero, because the reset bit
// has cleared itself again before software can read it back.
//
// Timing seen from the port.
// Edge 0: a request is taken.
// Edge 1: read data, the clear pulse and the MMD reset pulse stand for one cycle.
// Edge 2: the soft reset pulse stands for one cycle.
// Read data is zero in every cycle that follows no read, and for unmapped addresses.
// Every output comes from a flip-flop, so nothing combinational reaches the pins.
//
// Limitations.
// The bank does not check that the engine is idle before a configuration write. A
// write in mid-measurement changes the engine's levels at once; the engine must latch
// its own copy at the start of a run if it needs them steady.
// The bank does not stretch the reset pulses. A consumer in a slower domain must
// widen or synchronise them itself.
// Back-to-back MMD reset writes give back-to-back pulses; nothing merges them.
//
// State layout.
// All storage sits in one packed struct. One combinational process computes the next
// copy, and one clocked process registers it. Self clearing bits default to zero in the
// next copy, which makes them one-cycle pulses without any extra counters.
// The read data word is part of the same struct, so a read answers exactly one cycle
// after it is taken and drops back to zero on the cycle after that, unless another read was taken on the next edge.
module cdreg_bank (
    input  wire logic                  clk_in,
    input  wire logic                  resetn_in,
    input  wire cdreg_pkg::cdreg_req_t req_in,
    input  wire cdreg_pkg::cdreg_diag_t diag_in,
    output logic [15:0]                rdata_out,
    output cdreg_pkg::cdreg_cfg_t      cfg_out,
    output logic                       diag_clear_out,
    output logic                       mmd_set_reset_out,
    output logic                       soft_reset_out
);
    import cdreg_pkg::*;

    // Whole state of the bank in one packed struct.
    typedef struct packed {
        cdreg_cfg_t  cfg;
        logic [7:0]  result;
        logic        done;
        logic        clear;
        logic        mmd_rst;
        logic        soft_rst;
        logic [15:0] rdata;
    } cdreg_state_t;

    cdreg_state_t state_ff;   // Registered state.
    cdreg_state_t nxt_state;  // Next state.

    // Address decode used for reads and writes alike.
    function automatic logic hit(input cdreg_req_t r, input logic mmd3, input logic [15:0] off);
        hit = (r.mmd3 == mmd3) && (r.addr == off);
    endfunction : hit

    // Next state: register writes, self clearing pulses and engine results.
    always_comb begin
        nxt_state          = state_ff;
        nxt_state.clear    = 1'b0;
        nxt_state.mmd_rst  = 1'b0;
        // The soft reset follows the MMD reset pulse by one cycle.
        nxt_state.soft_rst = state_ff.mmd_rst;
        // The engine's report is latched; done is sticky until cleared.
        if (diag_in.done) begin
            nxt_state.done   = 1'b1;
            nxt_state.result = diag_in.result;
        end
        if (req_in.wr && hit(req_in, 1'b0, `CDREG_OFF_REFL_CFG)) begin
            nxt_state.cfg.skip_pairs_c_d       = req_in.wdata[`CDREG_BIT_SKIP_CD];
            nxt_state.cfg.cross_listen_disable = req_in.wdata[`CDREG_BIT_CROSS_DIS];
            nxt_state.cfg.link_pulse_check     = req_in.wdata[`CDREG_BIT_NLP_CHK];
            // The reserved averaging code leaves the old value in place.
            if (req_in.wdata[`CDREG_AVG_HI:`CDREG_AVG_LO] != `CDREG_AVG_RESERVED) begin
                nxt_state.cfg.average_count_sel = req_in.wdata[`CDREG_AVG_HI:`CDREG_AVG_LO];
            end
            nxt_state.cfg.segment_count = req_in.wdata[`CDREG_SEG_HI:`CDREG_SEG_LO];
            nxt_state.cfg.cycle_time_us = req_in.wdata[`CDREG_CYC_HI:`CDREG_CYC_LO];
        end
        // Clear wipes flag and result unless a finish lands in the same cycle; then the
        // finish's flag and result are kept, so no completion is lost.
        if (req_in.wr && hit(req_in, 1'b0, `CDREG_OFF_DIAG_CTRL) && req_in.wdata[`CDREG_BIT_CLEAR]) begin
            nxt_state.clear = 1'b1;
            nxt_state.done  = diag_in.done;
            nxt_state.result = diag_in.done ? diag_in.result : 8'h00;
        end
        // Only the indirect MMD3 path reaches the reset bit; other bits are dropped.
        if (req_in.wr && hit(req_in, 1'b1, `CDREG_OFF_PCS_CTRL) && req_in.wdata[`CDREG_BIT_MMD_RST]) begin
            nxt_state.mmd_rst = 1'b1;
        end
        // Read data is registered; unmapped addresses read zero.
        nxt_state.rdata = 16'h0000;
        if (req_in.rd) begin
            if (hit(req_in, 1'b0, `CDREG_OFF_REFL_CFG)) begin
                nxt_state.rdata[`CDREG_BIT_SKIP_CD]         = state_ff.cfg.skip_pairs_c_d;
                nxt_state.rdata[`CDREG_BIT_CROSS_DIS]       = state_ff.cfg.cross_listen_disable;
                nxt_state.rdata[`CDREG_BIT_NLP_CHK]         = state_ff.cfg.link_pulse_check;
                nxt_state.rdata[`CDREG_AVG_HI:`CDREG_AVG_LO] = state_ff.cfg.average_count_sel;
                nxt_state.rdata[`CDREG_SEG_HI:`CDREG_SEG_LO] = state_ff.cfg.segment_count;
                nxt_state.rdata[`CDREG_CYC_HI:`CDREG_CYC_LO] = state_ff.cfg.cycle_time_us;
            end else if (hit(req_in, 1'b0, `CDREG_OFF_DIAG_CTRL)) begin
                nxt_state.rdata[`CDREG_RES_HI:`CDREG_RES_LO] = state_ff.result;
                nxt_state.rdata[`CDREG_BIT_DONE]            = state_ff.done;
            end
            // The MMD3 control register always reads zero: its reset bit self clears.
        end
    end

    // State register with asynchronous reset to documented defaults.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_ff                          <= '0;
            state_ff.cfg.link_pulse_check     <= `CDREG_RST_NLP;
            state_ff.cfg.average_count_sel    <= `CDREG_RST_AVG;
            state_ff.cfg.segment_count        <= `CDREG_RST_SEG;
            state_ff.cfg.cycle_time_us        <= `CDREG_RST_CYC;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Outputs come straight from the state flip-flops.
    assign rdata_out         = state_ff.rdata;
    assign cfg_out           = state_ff.cfg;
    assign diag_clear_out    = state_ff.clear;
    assign mmd_set_reset_out = state_ff.mmd_rst;
    assign soft_reset_out    = state_ff.soft_rst;

    a_avg_never_rsv: assert property (@(posedge clk_in) disable iff (!resetn_in)
        state_ff.cfg.average_count_sel != `CDREG_AVG_RESERVED)
        else $error("Averaging field holds reserved code.");
    a_soft_after_mmd: assert property (@(posedge clk_in) disable iff (!resetn_in)
        mmd_set_reset_out |=> soft_reset_out)
        else $error("Soft reset did not follow MMD reset.");
    a_mmd_rst_pulse: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (req_in.wr && req_in.mmd3 && req_in.addr == `CDREG_OFF_PCS_CTRL && req_in.wdata[15])
        |=> mmd_set_reset_out ##1 !mmd_set_reset_out || $past(req_in.wr))
        else $error("MMD reset pulse missing.");
    a_direct_no_rst: assert property (@(posedge clk_in) disable iff (!resetn_in)
        mmd_set_reset_out |-> $past(req_in.mmd3))
        else $error("MMD reset without indirect access.");
    a_clear_done: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (diag_clear_out && !$past(diag_in.done)) |-> !state_ff.done && state_ff.result == 8'h00)
        else $error("Clear left done or result set.");
    a_done_sticky: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (state_ff.done && !nxt_state.clear) |=> state_ff.done)
        else $error("Done flag dropped without clear.");
    a_skip_write: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (req_in.wr && !req_in.mmd3 && req_in.addr == `CDREG_OFF_REFL_CFG)
        |=> cfg_out.skip_pairs_c_d == $past(req_in.wdata[12]))
        else $error("Pair skip bit not written.");
    a_cfg_stable: assert property (@(posedge clk_in) disable iff (!resetn_in)
        !(req_in.wr && !req_in.mmd3 && req_in.addr == `CDREG_OFF_REFL_CFG) |=> $stable(cfg_out))
        else $error("Configuration changed without write.");

    // A legal averaging code lands as written.
    a_avg_write_lands: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (req_in.wr && !req_in.mmd3 && req_in.addr == `CDREG_OFF_REFL_CFG
         && req_in.wdata[`CDREG_AVG_HI:`CDREG_AVG_LO] != `CDREG_AVG_RESERVED)
        |=> cfg_out.average_count_sel == $past(req_in.wdata[`CDREG_AVG_HI:`CDREG_AVG_LO]))
        else $error("Averaging code not written.");

    // The reserved averaging code leaves the stored code unchanged.
    a_avg_rsv_keeps: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (req_in.wr && !req_in.mmd3 && req_in.addr == `CDREG_OFF_REFL_CFG
         && req_in.wdata[`CDREG_AVG_HI:`CDREG_AVG_LO] == `CDREG_AVG_RESERVED)
        |=> $stable(cfg_out.average_count_sel))
        else $error("Reserved averaging code changed the field.");

    // The cross listen disable bit lands as written.
    a_cross_write: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (req_in.wr && !req_in.mmd3 && req_in.addr == `CDREG_OFF_REFL_CFG)
        |=> cfg_out.cross_listen_disable == $past(req_in.wdata[`CDREG_BIT_CROSS_DIS]))
        else $error("Cross listen bit not written.");

    // The link pulse check bit lands as written.
    a_pulse_chk_write: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (req_in.wr && !req_in.mmd3 && req_in.addr == `CDREG_OFF_REFL_CFG)
        |=> cfg_out.link_pulse_check == $past(req_in.wdata[`CDREG_BIT_NLP_CHK]))
        else $error("Link pulse check bit not written.");

    // The segment count lands as written.
    a_segment_write: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (req_in.wr && !req_in.mmd3 && req_in.addr == `CDREG_OFF_REFL_CFG)
        |=> cfg_out.segment_count == $past(req_in.wdata[`CDREG_SEG_HI:`CDREG_SEG_LO]))
        else $error("Segment count not written.");

    // The cycle time lands as written.
    a_cycle_write: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (req_in.wr && !req_in.mmd3 && req_in.addr == `CDREG_OFF_REFL_CFG)
        |=> cfg_out.cycle_time_us == $past(req_in.wdata[`CDREG_CYC_HI:`CDREG_CYC_LO]))
        else $error("Cycle time not written.");

    // A finish from the engine sets the flag and latches its result.
    a_done_sets: assert property (@(posedge clk_in) disable iff (!resetn_in)
        diag_in.done |=> state_ff.done && state_ff.result == $past(diag_in.result))
        else $error("Engine finish not latched.");

    // A read of the diagnostics register returns the stored flag and result.
    a_diag_read: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (req_in.rd && !req_in.mmd3 && req_in.addr == `CDREG_OFF_DIAG_CTRL)
        |=> rdata_out == {$past(state_ff.result), 2'b00, $past(state_ff.done), 5'b00000})
        else $error("Diagnostics read data wrong.");

    // A clear write raises the clear pulse on the next cycle.
    a_clear_pulse: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (req_in.wr && !req_in.mmd3 && req_in.addr == `CDREG_OFF_DIAG_CTRL
         && req_in.wdata[`CDREG_BIT_CLEAR]) |=> diag_clear_out)
        else $error("Clear pulse missing.");

    // The clear pulse never appears without a clear write before it.
    a_clear_source: assert property (@(posedge clk_in) disable iff (!resetn_in)
        diag_clear_out |-> $past(req_in.wr && !req_in.mmd3 && req_in.addr == `CDREG_OFF_DIAG_CTRL
                                 && req_in.wdata[`CDREG_BIT_CLEAR]))
        else $error("Clear pulse without clear write.");

    // A clear with no finish in the same cycle leaves the flag low.
    a_clear_drops: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (req_in.wr && !req_in.mmd3 && req_in.addr == `CDREG_OFF_DIAG_CTRL
         && req_in.wdata[`CDREG_BIT_CLEAR] && !diag_in.done) |=> !state_ff.done)
        else $error("Clear left the done flag set.");

    // The soft reset pulse only ever follows the MMD reset pulse.
    a_soft_source: assert property (@(posedge clk_in) disable iff (!resetn_in)
        soft_reset_out |-> $past(mmd_set_reset_out))
        else $error("Soft reset without MMD reset.");

    // A direct write at the PCS offset never fires the MMD reset.
    a_direct_ignored: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (req_in.wr && !req_in.mmd3 && req_in.addr == `CDREG_OFF_PCS_CTRL) |=> !mmd_set_reset_out)
        else $error("Direct write fired MMD reset.");

    // Writes to the reserved bits alone never fire the MMD reset.
    a_rsv_bits_ignored: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (req_in.wr && req_in.mmd3 && req_in.addr == `CDREG_OFF_PCS_CTRL
         && !req_in.wdata[`CDREG_BIT_MMD_RST]) |=> !mmd_set_reset_out)
        else $error("Reserved bits fired MMD reset.");

    // The Mmd_set_reset control register always reads zero.
    a_mmd_reads_zero: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (req_in.rd && req_in.mmd3 && req_in.addr == `CDREG_OFF_PCS_CTRL) |=> rdata_out == 16'h0000)
        else $error("MMD control register read nonzero.");

    // Read data drops to zero after any cycle without a read.
    a_idle_rdata_zero: assert property (@(posedge clk_in) disable iff (!resetn_in)
        !req_in.rd |=> rdata_out == 16'h0000)
        else $error("Read data not zero when idle.");
endmodule : cdreg_bank
`default_nettype wire

// *** common/cdreg_defs.svh ***
// Offsets, field positions and reset values of the cable diagnostics register bank.
`ifndef CDREG_DEFS_SVH
`define CDREG_DEFS_SVH
`define CDREG_OFF_PCS_CTRL      16'h0000
`define CDREG_OFF_REFL_CFG      16'h0180
`define CDREG_OFF_DIAG_CTRL     16'h01A7
`define CDREG_BIT_SKIP_CD       12
`define CDREG_BIT_CROSS_DIS     11
`define CDREG_BIT_NLP_CHK       10
`define CDREG_AVG_HI            9
`define CDREG_AVG_LO            7
`define CDREG_SEG_HI            6
`define CDREG_SEG_LO            4
`define CDREG_CYC_HI            3
`define CDREG_CYC_LO            0
`define CDREG_BIT_DONE          5
`define CDREG_BIT_CLEAR         4
`define CDREG_RES_HI            15
`define CDREG_RES_LO            8
`define CDREG_BIT_MMD_RST       15
`define CDREG_RST_AVG           3'h6
`define CDREG_AVG_RESERVED      3'h7
`define CDREG_RST_SEG           3'h5
`define CDREG_RST_CYC           4'h2
`define CDREG_RST_NLP           1'h1
`endif

// *** common/cdreg_pkg.sv ***
// Types shared by the cable diagnostics register bank.
package cdreg_pkg;
    // Reflectometry configuration fields as steered into the measurement engine.
    typedef struct packed {
        logic       skip_pairs_c_d;
        logic       cross_listen_disable;
        logic       link_pulse_check;
        logic [2:0] average_count_sel;
        logic [2:0] segment_count;
        logic [3:0] cycle_time_us;
    } cdreg_cfg_t;
    // Management access request.
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic        mmd3;
        logic [15:0] addr;
        logic [15:0] wdata;
    } cdreg_req_t;
    // Result reported by the diagnostics engine.
    typedef struct packed {
        logic       done;
        logic [7:0] result;
    } cdreg_diag_t;
endpackage : cdreg_pkg

// *** verification/cdreg_bank_test.sv ***
// Self-checking testbench for the cable diagnostics register bank.
`include "cdreg_defs.svh"
`timescale 1ns/10ps
`default_nettype none
// Compares two values as 16-bit words and counts the outcome.
`define CHK(nm, e, g) begin comparisons++; if (16'(g) !== 16'(e)) begin error_cnt++; \
    $display("[FAIL] %s expected %h seen %h", nm, 16'(e), 16'(g)); end end
module cdreg_bank_test import cdreg_pkg::*;;
    logic        clk_in;      // Device clock.
    logic        resetn_in;   // Active-low reset.
    cdreg_req_t  req;         // Management request.
    cdreg_diag_t diag;        // Diagnostics engine report.
    logic [15:0] rdata_out;   // Read data.
    cdreg_cfg_t  cfg_out;     // Configuration levels.
    logic        diag_clear_out;
    logic        mmd_set_reset_out;
    logic        soft_reset_out;
    int          error_cnt;
    int          comparisons;
    logic [15:0] rv;          // Last word read.
    cdreg_bank cdreg_bank_inst (.clk_in(clk_in), .resetn_in(resetn_in), .req_in(req), .diag_in(diag),
        .rdata_out(rdata_out), .cfg_out(cfg_out), .diag_clear_out(diag_clear_out),
        .mmd_set_reset_out(mmd_set_reset_out), .soft_reset_out(soft_reset_out));
    // Free-running 100 MHz clock.
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // One write, held for exactly one sampling edge; pulses are visible on return.
    task automatic wr(input logic m, input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_in) #1;
        req = '{wr: 1'b1, rd: 1'b0, mmd3: m, addr: a, wdata: d};
        @(posedge clk_in) #1;
        req = '0;
    endtask : wr
    // One read; the registered answer is taken in the cycle after the request.
    task automatic rd(input logic m, input logic [15:0] a, output logic [15:0] d);
        @(posedge clk_in) #1;
        req = '{wr: 1'b0, rd: 1'b1, mmd3: m, addr: a, wdata: 16'h0000};
        @(posedge clk_in) #1;
        req = '0;
        d = rdata_out;
    endtask : rd
    // Prints the counts and the verdict, then ends the run.
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run
    // Cuts a hang short; the whole sequence needs well under a thousand cycles.
    initial begin
        #100000;
        error_cnt++;
        complete_run();
    end
    // Main sequence of tests.
    initial begin
        error_cnt = 0;
        comparisons = 0;
        req = '0;
        diag = '0;
        resetn_in = 1'b0;
        repeat (20) @(posedge clk_in);
        #1 resetn_in = 1'b1;
        rd(1'b0, `CDREG_OFF_REFL_CFG, rv); `CHK("cfg reset", 16'h0752, rv)
        `CHK("cfg_out reset", 16'h0752, cfg_out)
        rd(1'b0, `CDREG_OFF_DIAG_CTRL, rv); `CHK("diag reset", 16'h0000, rv)
        $display("test reset values done");
        // Every legal averaging code, with the other fields at zero.
        for (int c = 0; c < 7; c++) begin
            wr(1'b0, `CDREG_OFF_REFL_CFG, 16'(c << 7));
            rd(1'b0, `CDREG_OFF_REFL_CFG, rv); `CHK("avg code", 16'(c << 7), rv)
        end
        // All fields but the segment count set, reserved bits written too; averaging code 7 must not land.
        wr(1'b0, `CDREG_OFF_REFL_CFG, 16'hFF8F);
        rd(1'b0, `CDREG_OFF_REFL_CFG, rv); `CHK("cfg reserved avg", 16'h1F0F, rv)
        `CHK("cfg_out fields", 16'h1F0F, cfg_out)
        wr(1'b0, `CDREG_OFF_REFL_CFG, 16'h09FA);
        rd(1'b0, `CDREG_OFF_REFL_CFG, rv); `CHK("cfg mixed", 16'h09FA, rv)
        $display("test reflectometry config done");
        // Engine finishes, result is latched, then a clear wipes it.
        @(posedge clk_in) #1 diag = '{done: 1'b1, result: 8'hA5};
        @(posedge clk_in) #1 diag = '0;
        rd(1'b0, `CDREG_OFF_DIAG_CTRL, rv); `CHK("diag result", 16'hA520, rv)
        wr(1'b0, `CDREG_OFF_DIAG_CTRL, 16'h0010); `CHK("clear pulse", 1, diag_clear_out)
        rd(1'b0, `CDREG_OFF_DIAG_CTRL, rv); `CHK("diag cleared", 16'h0000, rv)
        `CHK("clear pulse end", 0, diag_clear_out)
        rd(1'b0, `CDREG_OFF_DIAG_CTRL, rv); `CHK("done stays low", 16'h0000, rv)
        // A finish in the very cycle of a clear is kept.
        @(posedge clk_in) #1;
        req = '{wr: 1'b1, rd: 1'b0, mmd3: 1'b0, addr: `CDREG_OFF_DIAG_CTRL, wdata: 16'h0010};
        diag = '{done: 1'b1, result: 8'h3C};
        @(posedge clk_in) #1;
        req = '0;
        diag = '0;
        rd(1'b0, `CDREG_OFF_DIAG_CTRL, rv); `CHK("finish beats clear", 16'h3C20, rv)
        wr(1'b0, `CDREG_OFF_DIAG_CTRL, 16'h0010);
        rd(1'b0, `CDREG_OFF_DIAG_CTRL, rv); `CHK("second clear", 16'h0000, rv)
        $display("test diagnostics done");
        // Direct addressing must not reach the MMD reset.
        wr(1'b0, 16'h0000, 16'h8000); `CHK("direct no reset", 0, mmd_set_reset_out)
        @(posedge clk_in) #1; `CHK("direct no soft", 0, soft_reset_out)
        wr(1'b1, `CDREG_OFF_PCS_CTRL, 16'hFFFF); `CHK("mmd pulse", 1, mmd_set_reset_out)
        `CHK("soft not yet", 0, soft_reset_out)
        @(posedge clk_in) #1; `CHK("soft pulse", 1, soft_reset_out)
        `CHK("mmd pulse end", 0, mmd_set_reset_out)
        @(posedge clk_in) #1; `CHK("soft end", 0, soft_reset_out)
        rd(1'b1, `CDREG_OFF_PCS_CTRL, rv); `CHK("mmd reads zero", 16'h0000, rv)
        rd(1'b0, 16'h0123, rv); `CHK("unmapped", 16'h0000, rv)
        $display("test mmd reset done");
        complete_run();
    end
endmodule : cdreg_bank_test
`default_nettype wire
